// File: shb_pkg.sv
// Constants shared by both ends of the serial controller host bus port.
// Assumes one 50 MHz clock serves as the peripheral clock of both ends.
package shb_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_MHZ         = 50;
  localparam int RECOVERY_PCLK   = 4;
  localparam int SYNC_STAGES     = 2;
  localparam int HOST_SETUP_CYC  = 2;
  localparam int HOST_AS_CYC     = 2;
  localparam int HOST_AHOLD_CYC  = 4;
  localparam int HOST_STROBE_CYC = 8;
  localparam int HOST_GAP_CYC    = 4;

  // ==========================================================================
  // Register numbers
  // ==========================================================================
  localparam logic [3:0] REG_CMD   = 4'h0;
  localparam logic [3:0] REG_STAT1 = 4'h1;
  localparam logic [3:0] REG_VEC   = 4'h2;
  localparam logic [3:0] REG_PEND  = 4'h3;
  localparam logic [3:0] REG_DATA  = 4'h8;
  localparam logic [3:0] REG_MIC   = 4'h9;
  localparam logic [3:0] REG_MISC  = 4'hA;
  localparam logic [3:0] REG_TCL   = 4'hC;
  localparam logic [3:0] REG_TCH   = 4'hD;
  localparam logic [3:0] REG_EXT   = 4'hF;

  // ==========================================================================
  // Command register fields
  // ==========================================================================
  localparam int         PTR_MSB        = 2;
  localparam int         CMD_MSB        = 5;
  localparam int         CMD_LSB        = 3;
  localparam int         SHIFT_LEFT_BIT = 0;
  localparam logic [2:0] CMD_POINT_HIGH = 3'h1;
  localparam logic [2:0] CMD_RESET_IUS  = 3'h7;
  localparam logic [3:0] PTR_HIGH_OFS   = 4'h8;
  localparam logic       SHIFT_LEFT_RST = 1'b1;

  // ==========================================================================
  // Master interrupt control fields and vector status
  // ==========================================================================
  localparam int         MIC_VIS_BIT   = 0;
  localparam int         MIC_NV_BIT    = 1;
  localparam int         MIC_MIE_BIT   = 3;
  localparam int         NUM_IRQ       = 6;
  localparam logic [2:0] VEC_NONE_CODE = 3'h6;
  localparam logic [7:0] REG_RST       = 8'h00;

  // ==========================================================================
  // Host command kinds and states
  // ==========================================================================
  localparam logic [1:0] KIND_WRITE = 2'h0;
  localparam logic [1:0] KIND_READ  = 2'h1;
  localparam logic [1:0] KIND_ACK   = 2'h2;

  typedef enum logic [2:0] {
    H_IDLE   = 3'b000,
    H_ADDR   = 3'b001,
    H_AHOLD  = 3'b010,
    H_SETUP  = 3'b011,
    H_STROBE = 3'b100,
    H_GAP    = 3'b101
  } shb_host_state_t;

endpackage

// File: shb_if.sv
// Bus pins between the host and the serial controller, both bus variants.
// Assumes the testbench drives chain_enable_in from the upstream device.
interface shb_if;
  logic       ce_n;              // Chip enable, non-multiplexed.
  logic       rd_n;              // Read strobe, non-multiplexed.
  logic       wr_n;              // Write strobe, non-multiplexed.
  logic       chan_b;            // Channel select, high for channel B.
  logic       data_sel;          // High selects the data register.
  logic       irq_acknowledge_n; // Interrupt acknowledge.
  logic       addr_strobe_n;     // Address strobe, multiplexed.
  logic       data_strobe_n;     // Data strobe, multiplexed.
  logic       chip_select_low_n; // Chip select latched with the address.
  logic       chip_select_high;  // Chip select sampled with data strobe.
  logic       read_not_write;    // High for read.
  logic [7:0] host_bus;          // Host drive of the data bus.
  logic       host_bus_oe_n;     // Low while the host drives the bus.
  logic [7:0] dev_bus;           // Device drive of the data bus.
  logic       dev_bus_oe_n;      // Low while the device drives the bus.
  logic [7:0] muxed_bus;         // Resolved level of the data bus.
  logic       chain_enable_in;   // Daisy chain from higher priority.
  logic       chain_enable_out;  // Daisy chain to lower priority.
  logic       irq_oe_n;          // Low while the device pulls irq low.
  logic       irq_n;             // Resolved open-drain interrupt line.

  assign muxed_bus = !dev_bus_oe_n ? dev_bus : (!host_bus_oe_n ? host_bus : 8'hFF);
  assign irq_n     = irq_oe_n;

  modport dev (
    input  ce_n, rd_n, wr_n, chan_b, data_sel, irq_acknowledge_n,
    input  addr_strobe_n, data_strobe_n, chip_select_low_n, chip_select_high,
    input  read_not_write, muxed_bus, chain_enable_in,
    output dev_bus, dev_bus_oe_n, chain_enable_out, irq_oe_n
  );

  modport host (
    output ce_n, rd_n, wr_n, chan_b, data_sel, irq_acknowledge_n,
    output addr_strobe_n, data_strobe_n, chip_select_low_n, chip_select_high,
    output read_not_write, host_bus, host_bus_oe_n,
    input  muxed_bus, irq_n
  );
endinterface

// File: shb_device.sv
// Device end of the serial controller host bus port, either bus variant.
// Assumes the host keeps strobe spacing; engines supply status and pending.
// Behaviour
// - Data select high reaches data register directly.
// - Command write latches three-bit register pointer.
// - Next access goes to pointed register.
// - Pointer clears after the following access.
// - Pointer can also reach data registers.
// - Multiplexed: direct addressing, mode set via B.
// - Shift right: channel from bit 0.
// - Shift left: channel from bit 5.
// - Bits 7:6 ignored, register from 4:1.
// - Time constant and status read registers returned.
// - Vector plain on A, modified on B.
// - One shared vector and interrupt control.
// - Host programs mode, interrupts, then enables.
// - Four clocks between successive strobe falls.
// - Multiplexed spacing measured data strobe falls.
// - Host holds selects; strobe needs chip enable.
// - Host sets write data before strobe.
// - Non-multiplexed acknowledge drives vector, sets service.
// - Address strobe rise latches address, selects.
// - Multiplexed write captures data while strobe low.
// - Acknowledge ignores address, selects and direction.
// - Multiplexed acknowledge drives vector, sets service.
module shb_device #(
  parameter bit MUXED = 1'b0
) (
  input  wire logic                 clk_sys,      // System clock.
  input  wire logic                 srst,         // Synchronous reset.
  shb_if.dev                        bus,          // Host bus pins.
  input  wire logic [1:0][3:0][7:0] status_in,    // Status 0, 1, 10, 15.
  input  wire logic [1:0][7:0]      rx_data,      // Receive buffers.
  input  wire logic [5:0]           pending_bits, // Interrupt requests.
  output logic      [1:0][15:0][7:0] ctrl_regs,   // Write registers.
  output logic      [1:0]           tx_strobe,    // Transmit buffer write.
  output logic      [7:0]           tx_data,      // Transmit byte.
  output logic      [1:0]           rx_read,      // Receive buffer read.
  output logic      [5:0]           in_service    // Service latches.
);

  // ==========================================================================
  // Strobe synchronisers
  // ==========================================================================
  localparam int NS = 4;
  logic [NS-1:0] raw;
  logic [NS-1:0] sync1_reg;
  logic [NS-1:0] sync2_reg;
  logic [NS-1:0] dly_reg;
  logic [NS-1:0] fall;
  logic [NS-1:0] rise;

  // strobe qualified by enable; acknowledge reads need no enable.
  assign raw[0] = bus.rd_n | (bus.ce_n & bus.irq_acknowledge_n);
  assign raw[1] = bus.wr_n | bus.ce_n;
  assign raw[2] = bus.addr_strobe_n;
  assign raw[3] = bus.data_strobe_n;

  genvar gi;
  generate
    for (gi = 0; gi < NS; gi++) begin : g_sync
      always_ff @(posedge clk_sys) begin
        if (srst) begin
          sync1_reg[gi] <= 1'b1;
          sync2_reg[gi] <= 1'b1;
          dly_reg[gi]   <= 1'b1;
        end else begin
          sync1_reg[gi] <= raw[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          dly_reg[gi]   <= sync2_reg[gi];
        end
      end
      assign fall[gi] = dly_reg[gi] & ~sync2_reg[gi];
      assign rise[gi] = ~dly_reg[gi] & sync2_reg[gi];
    end
  endgenerate

  // ==========================================================================
  // Address latch of the multiplexed variant
  // ==========================================================================
  logic [7:0] lat_addr_reg;
  logic       lat_cs0_n_reg;
  logic       lat_ack_n_reg;
  logic       shift_left_reg;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      lat_addr_reg  <= 8'h00;
      lat_cs0_n_reg <= 1'b1;
      lat_ack_n_reg <= 1'b1;
    end else if (MUXED && rise[2]) begin
      lat_addr_reg  <= bus.muxed_bus;
      lat_cs0_n_reg <= bus.chip_select_low_n;
      lat_ack_n_reg <= bus.irq_acknowledge_n;
    end
  end

  // ==========================================================================
  // Access decode
  // ==========================================================================
  logic [3:0] ptr_reg;
  logic       acc_rd;
  logic       acc_wr;
  logic       acc_ack;
  logic       acc_end;
  logic       acc_chan;
  logic [3:0] acc_reg;
  logic [7:0] wdata;

  assign wdata = bus.muxed_bus;

  always_comb begin
    acc_rd   = 1'b0;
    acc_wr   = 1'b0;
    acc_ack  = 1'b0;
    acc_end  = 1'b0;
    acc_chan = 1'b0;
    acc_reg  = shb_pkg::REG_CMD;
    if (MUXED) begin
      // register from bits 4:1, bits 7:6 unused.
      acc_reg = lat_addr_reg[4:1];
      acc_chan = shift_left_reg ? lat_addr_reg[5] : lat_addr_reg[0];
      acc_end  = rise[3];
      if (fall[3]) begin
        if (!lat_ack_n_reg) begin
          acc_ack = 1'b1;
        end else if (!lat_cs0_n_reg && bus.chip_select_high) begin
          acc_rd = bus.read_not_write;
          acc_wr = !bus.read_not_write;
        end
      end
    end else begin
      acc_chan = bus.chan_b;
      // otherwise the pointer names the register.
      acc_reg = bus.data_sel ? shb_pkg::REG_DATA : ptr_reg;
      acc_end = rise[0];
      acc_ack = fall[0] && !bus.irq_acknowledge_n;
      acc_rd  = fall[0] && bus.irq_acknowledge_n;
      acc_wr  = fall[1];
    end
  end

  // ==========================================================================
  // Pointer and write registers
  // ==========================================================================
  logic [7:0] vec_reg;
  logic [7:0] mic_reg;
  logic       cmd_wr;

  assign cmd_wr = acc_wr && (acc_reg == shb_pkg::REG_CMD);

  always_ff @(posedge clk_sys) begin
    if (srst || MUXED) begin
      ptr_reg <= 4'h0;
    end else if (cmd_wr) begin
      ptr_reg <= {1'b0, wdata[shb_pkg::PTR_MSB:0]} |
                 ((wdata[shb_pkg::CMD_MSB:shb_pkg::CMD_LSB] == shb_pkg::CMD_POINT_HIGH) ?
                  shb_pkg::PTR_HIGH_OFS : 4'h0);
    end else if (acc_rd || acc_wr) begin
      ptr_reg <= 4'h0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl_regs <= '0;
      vec_reg   <= shb_pkg::REG_RST;
      mic_reg   <= shb_pkg::REG_RST;
    end else if (acc_wr) begin
      // shared vector and control through either channel.
      if (acc_reg == shb_pkg::REG_VEC) begin
        vec_reg <= wdata;
      end else if (acc_reg == shb_pkg::REG_MIC) begin
        mic_reg <= wdata;
      end else begin
        ctrl_regs[acc_chan][acc_reg] <= wdata;
      end
    end
  end

  // shift mode set through channel B command.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      shift_left_reg <= shb_pkg::SHIFT_LEFT_RST;
    end else if (MUXED && cmd_wr && acc_chan) begin
      shift_left_reg <= wdata[shb_pkg::SHIFT_LEFT_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tx_strobe <= 2'b00;
      tx_data   <= 8'h00;
      rx_read   <= 2'b00;
    end else begin
      tx_strobe <= 2'b00;
      rx_read   <= 2'b00;
      if (acc_reg == shb_pkg::REG_DATA) begin
        tx_strobe[acc_chan] <= acc_wr;
        rx_read[acc_chan]   <= acc_rd;
      end
      if (acc_wr) begin
        tx_data <= wdata;
      end
    end
  end

  // ==========================================================================
  // Interrupt state and vector
  // ==========================================================================
  function automatic logic [2:0] top_idx(input logic [5:0] v);
    logic [2:0] idx;
    idx = shb_pkg::VEC_NONE_CODE;
    for (int i = 0; i < shb_pkg::NUM_IRQ; i++) begin
      if (v[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  logic       irq_any;
  logic [2:0] pend_idx;
  logic [7:0] mod_vec;
  logic       ack_mine;

  assign irq_any  = mic_reg[shb_pkg::MIC_MIE_BIT] && (pending_bits != 6'h00);
  assign pend_idx = top_idx(pending_bits);
  assign mod_vec  = mic_reg[shb_pkg::MIC_VIS_BIT] ?
                    {vec_reg[7:4], pend_idx, vec_reg[0]} : vec_reg;
  assign ack_mine = acc_ack && irq_any && bus.chain_enable_in;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      in_service <= 6'h00;
    end else if (ack_mine) begin
      in_service <= in_service | (6'h01 << pend_idx);
    end else if (cmd_wr &&
                 wdata[shb_pkg::CMD_MSB:shb_pkg::CMD_LSB] == shb_pkg::CMD_RESET_IUS &&
                 in_service != 6'h00) begin
      in_service <= in_service & ~(6'h01 << top_idx(in_service));
    end
  end

  // chain blocked while pending or served.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bus.chain_enable_out <= 1'b0;
      bus.irq_oe_n         <= 1'b1;
    end else begin
      bus.chain_enable_out <= bus.chain_enable_in && !irq_any && (in_service == 6'h00);
      bus.irq_oe_n         <= !(irq_any && (in_service == 6'h00));
    end
  end

  // ==========================================================================
  // Read data
  // ==========================================================================
  logic [7:0] rdata;

  always_comb begin
    rdata = 8'h00;
    unique case (acc_reg)
      shb_pkg::REG_CMD:   rdata = status_in[acc_chan][0];
      shb_pkg::REG_STAT1: rdata = status_in[acc_chan][1];
      shb_pkg::REG_VEC:   rdata = acc_chan ? mod_vec : vec_reg;
      shb_pkg::REG_PEND:  rdata = acc_chan ? 8'h00 : {2'b00, pending_bits};
      shb_pkg::REG_DATA:  rdata = rx_data[acc_chan];
      shb_pkg::REG_MISC:  rdata = status_in[acc_chan][2];
      shb_pkg::REG_TCL:   rdata = ctrl_regs[acc_chan][shb_pkg::REG_TCL];
      shb_pkg::REG_TCH:   rdata = ctrl_regs[acc_chan][shb_pkg::REG_TCH];
      shb_pkg::REG_EXT:   rdata = status_in[acc_chan][3];
      default:            rdata = 8'h00;
    endcase
  end

  // Drivers stay on until the strobe is seen to rise.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bus.dev_bus      <= 8'h00;
      bus.dev_bus_oe_n <= 1'b1;
    end else if (acc_rd) begin
      bus.dev_bus      <= rdata;
      bus.dev_bus_oe_n <= 1'b0;
    end else if (ack_mine && !mic_reg[shb_pkg::MIC_NV_BIT]) begin
      bus.dev_bus      <= mod_vec;
      bus.dev_bus_oe_n <= 1'b0;
    end else if (acc_end) begin
      bus.dev_bus_oe_n <= 1'b1;
    end
  end

endmodule

// File: shb_host.sv
// Host end of the serial controller host bus port, either bus variant.
// Assumes the user issues pointer writes itself before pointed accesses.
module shb_host #(
  parameter bit MUXED      = 1'b0,
  parameter int STROBE_CYC = shb_pkg::HOST_STROBE_CYC,
  parameter int GAP_CYC    = shb_pkg::HOST_GAP_CYC
) (
  input  wire logic       clk_sys,        // System clock.
  input  wire logic       srst,           // Synchronous reset.
  shb_if.host             bus,            // Device bus pins.
  input  wire logic       cmd_valid,      // Command request.
  output logic            cmd_ready,      // Ready for a command.
  input  wire logic [1:0] cmd_kind,       // Write, read or acknowledge.
  input  wire logic       cmd_chan,       // Channel B when high.
  input  wire logic       cmd_dc,         // Data select, non-multiplexed.
  input  wire logic [3:0] cmd_reg,        // Register, multiplexed.
  input  wire logic       cmd_shift_left, // Address mode, multiplexed.
  input  wire logic [7:0] cmd_wdata,      // Write data.
  output logic            rsp_valid,      // Read or vector data valid.
  output logic [7:0]      rsp_data,       // Read or vector data.
  output logic            irq_pending     // Interrupt line low.
);

  if (STROBE_CYC < 6 || STROBE_CYC > 15 || GAP_CYC < 4 || GAP_CYC > 15 ||
      STROBE_CYC + GAP_CYC < shb_pkg::RECOVERY_PCLK) begin : g_bad_timing
    $error("shb_host timing parameters out of range");
  end

  shb_pkg::shb_host_state_t state_reg;
  logic [3:0] cnt_reg;
  logic [1:0] kind_reg;
  logic [7:0] wdata_reg;
  logic       is_ack;
  logic [7:0] addr;

  assign is_ack = (cmd_kind == shb_pkg::KIND_ACK);
  assign addr = cmd_shift_left ? {2'b00, cmd_chan, cmd_reg, 1'b0} :
                                 {3'b000, cmd_reg, cmd_chan};

  always_ff @(posedge clk_sys) begin
    irq_pending <= srst ? 1'b0 : !bus.irq_n;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg                 <= shb_pkg::H_IDLE;
      cnt_reg                   <= 4'h0;
      kind_reg                  <= shb_pkg::KIND_WRITE;
      wdata_reg                 <= 8'h00;
      cmd_ready                 <= 1'b0;
      rsp_valid                 <= 1'b0;
      rsp_data                  <= 8'h00;
      bus.ce_n                  <= 1'b1;
      bus.rd_n                  <= 1'b1;
      bus.wr_n                  <= 1'b1;
      bus.chan_b                <= 1'b0;
      bus.data_sel              <= 1'b0;
      bus.irq_acknowledge_n     <= 1'b1;
      bus.addr_strobe_n         <= 1'b1;
      bus.data_strobe_n         <= 1'b1;
      bus.chip_select_low_n     <= 1'b1;
      bus.chip_select_high      <= 1'b0;
      bus.read_not_write        <= 1'b1;
      bus.host_bus              <= 8'h00;
      bus.host_bus_oe_n         <= 1'b1;
    end else begin
      rsp_valid <= 1'b0;
      cnt_reg   <= cnt_reg + 4'h1;
      unique case (state_reg)
        shb_pkg::H_IDLE: begin
          cmd_ready <= 1'b1;
          if (cmd_valid && cmd_ready) begin
            cmd_ready             <= 1'b0;
            cnt_reg               <= 4'h0;
            kind_reg              <= cmd_kind;
            wdata_reg             <= cmd_wdata;
            // selects held for the whole cycle.
            bus.chan_b            <= cmd_chan;
            bus.data_sel          <= cmd_dc;
            bus.irq_acknowledge_n <= !is_ack;
            bus.read_not_write    <= (cmd_kind != shb_pkg::KIND_WRITE);
            if (MUXED) begin
              bus.host_bus          <= addr;
              bus.host_bus_oe_n     <= 1'b0;
              bus.addr_strobe_n     <= 1'b0;
              bus.chip_select_low_n <= is_ack;
              state_reg             <= shb_pkg::H_ADDR;
            end else begin
              bus.host_bus      <= cmd_wdata;
              bus.host_bus_oe_n <= (cmd_kind != shb_pkg::KIND_WRITE);
              bus.ce_n          <= is_ack;
              state_reg         <= shb_pkg::H_SETUP;
            end
          end
        end
        shb_pkg::H_ADDR: begin
          if (cnt_reg == 4'(shb_pkg::HOST_AS_CYC - 1)) begin
            bus.addr_strobe_n <= 1'b1;
            cnt_reg           <= 4'h0;
            state_reg         <= shb_pkg::H_AHOLD;
          end
        end
        shb_pkg::H_AHOLD, shb_pkg::H_SETUP: begin
          if (cnt_reg == 4'((MUXED ? shb_pkg::HOST_AHOLD_CYC : shb_pkg::HOST_SETUP_CYC) - 1))
          begin
            cnt_reg   <= 4'h0;
            state_reg <= shb_pkg::H_STROBE;
            if (MUXED) begin
              bus.host_bus         <= wdata_reg;
              bus.host_bus_oe_n    <= (kind_reg != shb_pkg::KIND_WRITE);
              bus.chip_select_high <= 1'b1;
              bus.data_strobe_n    <= 1'b0;
            end else begin
              bus.rd_n <= (kind_reg == shb_pkg::KIND_WRITE);
              bus.wr_n <= (kind_reg != shb_pkg::KIND_WRITE);
            end
          end
        end
        shb_pkg::H_STROBE: begin
          if (cnt_reg == 4'(STROBE_CYC - 1)) begin
            cnt_reg               <= 4'h0;
            rsp_valid             <= (kind_reg != shb_pkg::KIND_WRITE);
            rsp_data              <= bus.muxed_bus;
            bus.rd_n              <= 1'b1;
            bus.wr_n              <= 1'b1;
            bus.data_strobe_n     <= 1'b1;
            bus.ce_n              <= 1'b1;
            bus.chip_select_high  <= 1'b0;
            bus.chip_select_low_n <= 1'b1;
            bus.irq_acknowledge_n <= 1'b1;
            bus.host_bus_oe_n     <= 1'b1;
            state_reg             <= shb_pkg::H_GAP;
          end
        end
        shb_pkg::H_GAP: begin
          if (cnt_reg == 4'(GAP_CYC - 1)) begin
            state_reg <= shb_pkg::H_IDLE;
          end
        end
        default: state_reg <= shb_pkg::H_IDLE;
      endcase
    end
  end

endmodule

// File: shb_props.sv
// Concurrent checks on the non-multiplexed host bus pins.
// Assumes it watches the interface that joins a host end to a device end.
module shb_props (
  input wire logic clk_sys,           // Clock.
  input wire logic srst,              // Reset.
  input wire logic ce_n,              // Chip enable.
  input wire logic rd_n,              // Read strobe.
  input wire logic wr_n,              // Write strobe.
  input wire logic irq_acknowledge_n, // Acknowledge.
  input wire logic host_bus_oe_n,     // Host drive.
  input wire logic dev_bus_oe_n,      // Device drive.
  input wire logic chain_enable_in,   // Chain in.
  input wire logic chain_enable_out,  // Chain out.
  input wire logic irq_oe_n           // Interrupt drive.
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  chain_in_low_a: assert property (!chain_enable_in |=> !chain_enable_out)
    else $error("chain out high while chain in low");
  irq_blocks_chain_a: assert property (!irq_oe_n |-> !chain_enable_out)
    else $error("chain out high while interrupt pending");
  bus_no_clash_a: assert property (!(!dev_bus_oe_n && !host_bus_oe_n))
    else $error("both ends drive the bus");
  drive_needs_read_a: assert property ($fell(dev_bus_oe_n) |-> !$past(rd_n, 3))
    else $error("bus driven without read strobe");
  drive_needs_sel_a: assert property ($fell(dev_bus_oe_n) |->
    !$past(ce_n, 3) || !$past(irq_acknowledge_n, 3))
    else $error("bus driven without chip enable");
  read_release_a: assert property ($rose(rd_n) |-> ##[1:6] dev_bus_oe_n)
    else $error("bus not released after read");
  write_quiet_a: assert property (!wr_n |-> dev_bus_oe_n)
    else $error("bus driven during write");
  sync_wait_a: assert property ($fell(rd_n) |-> dev_bus_oe_n [*2])
    else $error("strobe used before synchronising");
  drive_hold_a: assert property ($fell(dev_bus_oe_n) |=> !dev_bus_oe_n [*3])
    else $error("bus drive too short");
  read_cov: cover property ($fell(dev_bus_oe_n));
  ack_cov: cover property (!irq_acknowledge_n && !rd_n);
  chain_cov: cover property (!chain_enable_in ##1 !chain_enable_out);
endmodule

// File: serial_ctrl_host_bus_interface_tb.sv
// Testbench joining host and device ends, both bus variants.
// Assumes one clock for both ends and a floating bus reading all ones.
module serial_ctrl_host_bus_interface_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  clk_sys = 1'h0;
  logic                  srst = 1'h1;
  logic                  cmd_valid [2] = '{1'h0, 1'h0};
  logic                  cmd_ready [2], rsp_valid [2], irq_pend [2];
  logic [1:0]            kind = 2'h0;
  logic                  chan = 1'h0, dc = 1'h0, sl = 1'h1, chain_in = 1'h1;
  logic [3:0]            regn = 4'h0;
  logic [7:0]            wdata = 8'h00, rsp_data [2], tx_data [2];
  logic [1:0][15:0][7:0] ctrl_regs [2];
  logic [1:0]            tx_strobe [2], rx_read [2];
  logic [5:0]            in_service [2], pending_bits = 6'h00;
  logic [1:0][3:0][7:0]  status_in = 64'h0000_0000_0000_00C3;
  logic [1:0][7:0]       rx_data = 16'h005D;
  int                    n_fail = 0, check_count = 0;
  always #10 clk_sys = ~clk_sys;
  for (genvar m = 0; m < 2; m++) begin : g_var
    shb_if bif ();
    assign bif.chain_enable_in = chain_in;
    shb_device #(.MUXED(m == 1)) shb_device_inst (.clk_sys(clk_sys), .srst(srst), .bus(bif),
      .status_in(status_in), .rx_data(rx_data), .pending_bits(pending_bits),
      .ctrl_regs(ctrl_regs[m]), .tx_strobe(tx_strobe[m]), .tx_data(tx_data[m]),
      .rx_read(rx_read[m]), .in_service(in_service[m]));
    shb_host #(.MUXED(m == 1)) shb_host_inst (.clk_sys(clk_sys), .srst(srst), .bus(bif),
      .cmd_valid(cmd_valid[m]), .cmd_ready(cmd_ready[m]), .cmd_kind(kind), .cmd_chan(chan),
      .cmd_dc(dc), .cmd_reg(regn), .cmd_shift_left(sl), .cmd_wdata(wdata),
      .rsp_valid(rsp_valid[m]), .rsp_data(rsp_data[m]), .irq_pending(irq_pend[m]));
    if (m == 0) begin : g_chk
      shb_props shb_props_inst (.clk_sys(clk_sys), .srst(srst), .ce_n(bif.ce_n),
        .rd_n(bif.rd_n), .wr_n(bif.wr_n), .irq_acknowledge_n(bif.irq_acknowledge_n),
        .host_bus_oe_n(bif.host_bus_oe_n), .dev_bus_oe_n(bif.dev_bus_oe_n),
        .chain_enable_in(bif.chain_enable_in), .chain_enable_out(bif.chain_enable_out),
        .irq_oe_n(bif.irq_oe_n));
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Issues one host command and waits for the host to be idle again.
  task automatic op(input int m, input logic [1:0] k, input logic c, input logic [3:0] r,
                    input logic [7:0] w, output logic [7:0] d);
    int n;
    n = 0;
    kind = k;
    chan = c;
    regn = r;
    dc = (r == 4'h8);
    wdata = w;
    cmd_valid[m] = 1'h1;
    while (cmd_ready[m] !== 1'h1 && n < 60) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    @(posedge clk_sys);
    #1;
    cmd_valid[m] = 1'h0;
    d = 8'hEE;
    while (cmd_ready[m] !== 1'h1 && n < 60) begin
      @(posedge clk_sys);
      #1;
      n++;
      if (rsp_valid[m] === 1'h1)
        d = rsp_data[m];
    end
    if (n >= 60) begin
      n_fail++;
      tally_and_finish();
    end
  endtask
  task automatic nm_pointer();
    logic [7:0] d;
    op(0, 2'h0, 1'h0, 4'h0, 8'h02, d);
    op(0, 2'h0, 1'h0, 4'h0, 8'hF1, d);
    op(0, 2'h0, 1'h0, 4'h0, 8'h02, d);
    op(0, 2'h1, 1'h0, 4'h0, 8'h00, d);
    chk(d, 8'hF1);
    op(0, 2'h1, 1'h0, 4'h0, 8'h00, d);
    chk(d, 8'hC3);
    op(0, 2'h0, 1'h0, 4'h0, 8'h0C, d);
    op(0, 2'h0, 1'h0, 4'h0, 8'h3C, d);
    chk(ctrl_regs[0][0][12], 8'h3C);
    op(0, 2'h0, 1'h0, 4'h0, 8'h0C, d);
    op(0, 2'h1, 1'h0, 4'h0, 8'h00, d);
    chk(d, 8'h3C);
    op(0, 2'h0, 1'h0, 4'h0, 8'h08, d);
    op(0, 2'h0, 1'h0, 4'h0, 8'h66, d);
    chk(tx_data[0], 8'h66);
    op(0, 2'h1, 1'h0, 4'h8, 8'h00, d);
    chk(d, 8'h5D);
  endtask
  task automatic nm_ack();
    logic [7:0] d;
    op(0, 2'h0, 1'h0, 4'h0, 8'h09, d);
    op(0, 2'h0, 1'h0, 4'h0, 8'h09, d);
    pending_bits = 6'h04;
    repeat (2) @(posedge clk_sys);
    #1;
    chk({7'h0, irq_pend[0]}, 8'h01);
    op(0, 2'h2, 1'h0, 4'h0, 8'h00, d);
    chk(d, 8'hF5);
    chk({2'h0, in_service[0]}, 8'h04);
    chk({7'h0, irq_pend[0]}, 8'h00);
    chain_in = 1'h0;
    op(0, 2'h2, 1'h0, 4'h0, 8'h00, d);
    chk(d, 8'hFF);
    chain_in = 1'h1;
    pending_bits = 6'h00;
  endtask
  task automatic mx_decode();
    logic [7:0] d;
    op(1, 2'h0, 1'h1, 4'hC, 8'h5A, d);
    op(1, 2'h1, 1'h1, 4'hC, 8'h00, d);
    chk(d, 8'h5A);
    chk(ctrl_regs[1][0][12], 8'h00);
    op(1, 2'h0, 1'h1, 4'h0, 8'h00, d);
    sl = 1'h0;
    op(1, 2'h0, 1'h1, 4'hD, 8'h77, d);
    chk(ctrl_regs[1][1][13], 8'h77);
    chk(ctrl_regs[1][0][13], 8'h00);
    op(1, 2'h0, 1'h1, 4'h2, 8'h3C, d);
    op(1, 2'h1, 1'h0, 4'h2, 8'h00, d);
    chk(d, 8'h3C);
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    #1;
    srst = 1'h0;
    nm_pointer();
    nm_ack();
    mx_decode();
    tally_and_finish();
  end
endmodule
